// >>> csl_config_end.sv
// Loader end: streams configuration bytes to target chains and owns the flash bus.
// Assumes a decompressor feeds bytes on clk; the link side runs on link_clk.
//
// Function
// - Serial mode: one bit per clock, line 0
// - Concurrent mode drives n lines, n=1,2,4,8
// - Lines above n driven low
// - Odd chain counts use next wider mode
// - Upstream done enables downstream target capture; here it only sets cap_stage, capture is not gated by it
// - Chain shares one done line
// - Any status-low error restarts whole chain
// - No cascading of loader devices
// - Host uses flash only when loader released
// - Host floats and ignores flash during loader access
// - Loader drives flash only for reads/programming/options
// - Release flash and idle when finished
// - Held reconfiguration request keeps loader reset
// - Never tie flash buses of two loaders
// - Loader flash cycles visible on pins
// - Host may use spare flash space
// - Status/done pull-ups on unless disabled
// - Targets capture on rising shift clock
// - Start only with status high, done low
// - Done not high in 64 clocks: pulse status
// - No data ready: stop shift clock
`timescale 1ns/1ps
module csl_config_end (
  // System
  input wire logic clk,
  input wire logic rst,
  // Link clock
  input wire logic link_clk,
  // Decompressed byte feed
  input wire logic feed_valid,
  output logic feed_ready,
  input wire logic [csl_pkg::DATA_W-1:0] feed_byte,
  input wire logic feed_last,
  input wire csl_pkg::csl_width_e feed_width,
  // Flash ownership and options
  input wire logic opt_fetch,
  input wire logic prog_write,
  input wire logic [csl_pkg::FLASH_AW-1:0] reader_addr,
  input wire logic pullup_off,
  // Progress
  output logic cfg_active,
  output logic cfg_done,
  // Link
  csl_link_if.device lnk
);
  logic lrst_meta, lrst;
  logic x_valid, x_ready, x_last;
  logic [csl_pkg::WORD_W-1:0] x_data;
  logic [csl_pkg::DATA_W-1:0] x_byte, data_reg, sh_reg, src, chunk;
  csl_pkg::csl_width_e x_width, width_reg, width_use;
  logic status_meta, status_s, done_meta, done_s;
  csl_pkg::csl_state_e state_reg, state_next;
  logic sclk_reg, have_chunk_reg, fin_reg, first_reg;
  logic [2:0] half_reg, slots_reg;
  logic [6:0] tail_reg;
  logic [5:0] pulse_reg;
  logic active_reg, idle_reg, act_meta, act_s, idl_meta, idl_s;
  logic flash_own_reg, pull_en_reg;
  logic [csl_pkg::FLASH_AW-1:0] flash_addr_reg;
  logic run, fall, load_slot, take, load;
  logic [3:0] lines;
  // Link domain reset: asserts with rst, releases on link_clk
  always_ff @(posedge link_clk or posedge rst) begin
    if (rst) begin
      {lrst_meta, lrst} <= '1;
    end else begin
      {lrst_meta, lrst} <= {1'b0, lrst_meta};
    end
  end
  csl_word_xfer #(
    .WIDTH(csl_pkg::WORD_W)
  ) u_xfer (
    .src_clk(clk),
    .src_rst(rst),
    .in_valid(feed_valid),
    .in_ready(feed_ready),
    .in_data({feed_width, feed_last, feed_byte}),
    .dst_clk(link_clk),
    .dst_rst(lrst),
    .out_valid(x_valid),
    .out_ready(x_ready),
    .out_data(x_data)
  );
  assign x_byte = x_data[csl_pkg::DATA_W-1:0];
  assign x_last = x_data[csl_pkg::WORD_LAST_BIT];
  assign x_width = csl_pkg::csl_width_e'(x_data[csl_pkg::WORD_W-1:csl_pkg::WORD_WID_LSB]);
  always_ff @(posedge link_clk or posedge lrst) begin
    if (lrst) begin
      {status_meta, status_s, done_meta, done_s} <= '0;
    end else begin
      {status_meta, done_meta} <= {lnk.status_level, lnk.done_level};
      {status_s, done_s} <= {status_meta, done_meta};
    end
  end
  // Shift clock runs only with a chunk on the lines, or in the tail
  assign run = (state_reg == csl_pkg::CSL_TAIL) ||
               (state_reg == csl_pkg::CSL_SHIFT && have_chunk_reg);
  assign fall = run && sclk_reg && (half_reg == csl_pkg::HALF_LAST);
  assign load_slot = (state_reg == csl_pkg::CSL_SHIFT) && !sclk_reg && !have_chunk_reg;
  assign take = load_slot && (slots_reg == csl_pkg::SLOTS_NONE) && !fin_reg;
  // Words outside a transfer are dropped
  assign x_ready = take || (state_reg != csl_pkg::CSL_SHIFT);
  assign load = load_slot && ((slots_reg != csl_pkg::SLOTS_NONE) || (take && x_valid));
  assign width_use = (take && first_reg) ? x_width : width_reg;
  assign lines = csl_pkg::csl_lines(width_use);
  assign src = (slots_reg != csl_pkg::SLOTS_NONE) ? sh_reg : x_byte;
  // Line i carries the next bit of its own chain, or low when unused
  for (genvar gi = 0; gi < csl_pkg::DATA_W; gi++) begin : g_line
    assign chunk[gi] = (4'(gi) < lines) ? src[gi] : 1'b0;
  end
  always_comb begin
    state_next = state_reg;
    if (!status_s && state_reg != csl_pkg::CSL_ERR) begin
      state_next = csl_pkg::CSL_WAIT;
    end else begin
      case (state_reg)
        csl_pkg::CSL_WAIT: begin
          if (!done_s) begin
            state_next = csl_pkg::CSL_SHIFT;
          end
        end
        csl_pkg::CSL_SHIFT: begin
          if (load_slot && slots_reg == csl_pkg::SLOTS_NONE && fin_reg) begin
            state_next = csl_pkg::CSL_TAIL;
          end
        end
        csl_pkg::CSL_TAIL: begin
          if (done_s) begin
            state_next = csl_pkg::CSL_IDLE;
          end else if (fall && tail_reg == csl_pkg::DONE_WAIT_LAST) begin
            state_next = csl_pkg::CSL_ERR;
          end
        end
        csl_pkg::CSL_ERR: begin
          if (pulse_reg == csl_pkg::PULSE_LAST) begin
            state_next = csl_pkg::CSL_WAIT;
          end
        end
        csl_pkg::CSL_IDLE: state_next = csl_pkg::CSL_IDLE;
        default: state_next = csl_pkg::CSL_WAIT;
      endcase
    end
  end
  always_ff @(posedge link_clk or posedge lrst) begin
    if (lrst) begin
      state_reg <= csl_pkg::CSL_WAIT;
    end else begin
      state_reg <= state_next;
    end
  end
  always_ff @(posedge link_clk or posedge lrst) begin
    if (lrst) begin
      sclk_reg <= '0;
      half_reg <= '0;
    end else if (!run) begin
      sclk_reg <= '0;
      half_reg <= '0;
    end else if (half_reg == csl_pkg::HALF_LAST) begin
      sclk_reg <= !sclk_reg;
      half_reg <= '0;
    end else begin
      half_reg <= half_reg + 3'h1;
    end
  end
  // Byte slicing; width fixed from the first byte of a cycle
  always_ff @(posedge link_clk or posedge lrst) begin
    if (lrst) begin
      have_chunk_reg <= '0;
      sh_reg <= '0;
      slots_reg <= '0;
      fin_reg <= '0;
      first_reg <= '1;
      width_reg <= csl_pkg::CSL_W1;
    end else if (state_reg != csl_pkg::CSL_SHIFT) begin
      have_chunk_reg <= '0;
      slots_reg <= '0;
      fin_reg <= '0;
      first_reg <= '1;
    end else if (load) begin
      have_chunk_reg <= '1;
      sh_reg <= src >> lines;
      if (slots_reg != csl_pkg::SLOTS_NONE) begin
        slots_reg <= slots_reg - 3'h1;
      end else begin
        slots_reg <= csl_pkg::csl_slots(width_use);
        fin_reg <= x_last;
        first_reg <= '0;
        width_reg <= width_use;
      end
    end else if (fall) begin
      have_chunk_reg <= '0;
    end
  end
  // Data changes only in the low phase
  always_ff @(posedge link_clk or posedge lrst) begin
    if (lrst) begin
      data_reg <= csl_pkg::DATA_LOW;
    end else if (load) begin
      data_reg <= chunk;
    end else if (state_reg == csl_pkg::CSL_IDLE) begin
      data_reg <= csl_pkg::DATA_HIGH;
    end else if (state_reg != csl_pkg::CSL_SHIFT) begin
      data_reg <= csl_pkg::DATA_LOW;
    end
  end
  always_ff @(posedge link_clk or posedge lrst) begin
    if (lrst) begin
      tail_reg <= '0;
    end else if (state_reg != csl_pkg::CSL_TAIL) begin
      tail_reg <= '0;
    end else if (fall) begin
      tail_reg <= tail_reg + 7'h1;
    end
  end
  always_ff @(posedge link_clk or posedge lrst) begin
    if (lrst) begin
      pulse_reg <= '0;
    end else if (state_reg != csl_pkg::CSL_ERR) begin
      pulse_reg <= '0;
    end else begin
      pulse_reg <= pulse_reg + 6'h1;
    end
  end
  always_ff @(posedge link_clk or posedge lrst) begin
    if (lrst) begin
      active_reg <= '0;
      idle_reg <= '0;
    end else begin
      active_reg <= (state_reg == csl_pkg::CSL_SHIFT);
      idle_reg <= (state_reg == csl_pkg::CSL_IDLE);
    end
  end
  // Single loader drives status; no cascade port exists
  assign lnk.dev_status_out = '0;
  assign lnk.dev_status_oe = (state_reg == csl_pkg::CSL_ERR);
  assign lnk.config_shift_clock = sclk_reg;
  assign lnk.cfg_data = data_reg;
  // Progress back to clk
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      {act_meta, act_s, idl_meta, idl_s} <= '0;
    end else begin
      {act_meta, idl_meta} <= {active_reg, idle_reg};
      {act_s, idl_s} <= {act_meta, idl_meta};
    end
  end
  assign cfg_active = act_s;
  assign cfg_done = idl_s;
  // Flash bus owned only for option fetch, programming and config reads
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      flash_own_reg <= '0;
      flash_addr_reg <= '0;
    end else begin
      flash_own_reg <= opt_fetch || prog_write || act_s;
      flash_addr_reg <= (opt_fetch || prog_write || act_s) ? reader_addr : '0;
    end
  end
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pull_en_reg <= '1;
    end else begin
      pull_en_reg <= !pullup_off;
    end
  end
  assign lnk.dev_flash_oe = flash_own_reg;
  assign lnk.dev_flash_addr = flash_addr_reg;
  assign lnk.dev_pull_en = pull_en_reg;
endmodule

// >>> csl_pkg.sv
// Shared constants and types for the configuration stream loader.
// Assumes both ends and the crossing module refer to it by csl_pkg::name.
package csl_pkg;

  localparam int DATA_W = 8;
  localparam int FLASH_AW = 21;

  // Crossing word: {width, last, byte}
  localparam int WORD_W = 11;
  localparam int WORD_LAST_BIT = 8;
  localparam int WORD_WID_LSB = 9;

  // Link timing: periods in ns, counters in link clock cycles except the done wait, in shift clocks
  localparam int LINK_PERIOD_NS = 12;
  localparam logic [2:0] HALF_LAST = 3'h3;
  localparam logic [6:0] DONE_WAIT_LAST = 7'h3f;
  localparam int STATUS_PULSE_NS = 480;
  localparam int STATUS_PULSE_CYC = (STATUS_PULSE_NS + LINK_PERIOD_NS - 1) / LINK_PERIOD_NS;
  localparam logic [5:0] PULSE_LAST = 6'(STATUS_PULSE_CYC - 1);

  localparam logic [2:0] SLOTS_NONE = 3'h0;
  localparam logic [DATA_W-1:0] DATA_LOW = 8'h00;
  localparam logic [DATA_W-1:0] DATA_HIGH = 8'hff;

  typedef enum logic [1:0] {CSL_W1, CSL_W2, CSL_W4, CSL_W8} csl_width_e;

  typedef enum logic [2:0] {CSL_WAIT, CSL_SHIFT, CSL_TAIL, CSL_ERR, CSL_IDLE} csl_state_e;

  // Active data lines for a width
  function automatic logic [3:0] csl_lines(input csl_width_e w);
    case (w)
      CSL_W1: csl_lines = 4'h1;
      CSL_W2: csl_lines = 4'h2;
      CSL_W4: csl_lines = 4'h4;
      default: csl_lines = 4'h8;
    endcase
  endfunction

  // Shift clocks per byte, minus one
  function automatic logic [2:0] csl_slots(input csl_width_e w);
    case (w)
      CSL_W1: csl_slots = 3'h7;
      CSL_W2: csl_slots = 3'h3;
      CSL_W4: csl_slots = 3'h1;
      default: csl_slots = 3'h0;
    endcase
  endfunction

endpackage

// >>> csl_link_if.sv
// Link between the loader and its target chains plus the external flash host.
// Assumes open-drain lines are pulled high when nobody drives them low.
`timescale 1ns/1ps
interface csl_link_if;
  logic config_shift_clock;
  logic [csl_pkg::DATA_W-1:0] cfg_data;
  logic dev_status_out;
  logic dev_status_oe;
  logic tgt_status_out;
  logic tgt_status_oe;
  logic status_level;
  logic tgt_done_out;
  logic tgt_done_oe;
  logic done_level;
  logic dev_pull_en;
  logic dev_flash_oe;
  logic [csl_pkg::FLASH_AW-1:0] dev_flash_addr;
  logic host_flash_oe;
  logic [csl_pkg::FLASH_AW-1:0] host_flash_addr;
  logic [csl_pkg::FLASH_AW-1:0] flash_addr_level;

  // Wired status and done; pull-up internal or on the board
  assign status_level = !((dev_status_oe && !dev_status_out) ||
                          (tgt_status_oe && !tgt_status_out));
  assign done_level = !(tgt_done_oe && !tgt_done_out);
  // Shared flash pins; weak pull-ups show ones when floating
  assign flash_addr_level = dev_flash_oe ? dev_flash_addr :
                            (host_flash_oe ? host_flash_addr : '1);

  modport device (
    output config_shift_clock, cfg_data, dev_status_out, dev_status_oe, dev_pull_en,
    output dev_flash_oe, dev_flash_addr,
    input status_level, done_level
  );

  modport target (
    output tgt_status_out, tgt_status_oe, tgt_done_out, tgt_done_oe,
    output host_flash_oe, host_flash_addr,
    input config_shift_clock, cfg_data, status_level, done_level, dev_flash_oe,
    input flash_addr_level
  );
endinterface

// >>> csl_word_xfer.sv
// Toggle handshake carrying one word from a source clock to a destination clock.
// Assumes the destination takes a word only while out_valid is high.
`timescale 1ns/1ps
module csl_word_xfer #(
  parameter int WIDTH = csl_pkg::WORD_W
) (
  // Source side
  input wire logic src_clk,
  input wire logic src_rst,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  // Destination side
  input wire logic dst_clk,
  input wire logic dst_rst,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  logic req_reg;
  logic [WIDTH-1:0] data_reg;
  logic ack_meta;
  logic ack_sync;
  logic req_meta;
  logic req_sync;
  logic ack_reg;

  assign in_ready = (req_reg == ack_sync);
  assign out_valid = (req_sync != ack_reg);
  // Held stable until the acknowledge returns
  assign out_data = data_reg;

  always_ff @(posedge src_clk or posedge src_rst) begin
    if (src_rst) begin
      req_reg <= '0;
      data_reg <= '0;
    end else if (in_valid && in_ready) begin
      req_reg <= !req_reg;
      data_reg <= in_data;
    end
  end

  always_ff @(posedge src_clk or posedge src_rst) begin
    if (src_rst) begin
      ack_meta <= '0;
      ack_sync <= '0;
    end else begin
      ack_meta <= ack_reg;
      ack_sync <= ack_meta;
    end
  end

  always_ff @(posedge dst_clk or posedge dst_rst) begin
    if (dst_rst) begin
      req_meta <= '0;
      req_sync <= '0;
    end else begin
      req_meta <= req_reg;
      req_sync <= req_meta;
    end
  end

  always_ff @(posedge dst_clk or posedge dst_rst) begin
    if (dst_rst) begin
      ack_reg <= '0;
    end else if (out_valid && out_ready) begin
      ack_reg <= !ack_reg;
    end
  end
endmodule

// >>> csl_target_end.sv
// Target chains and external flash host facing the loader.
// Assumes clk is unrelated to the loader's link clock; all link inputs are synchronised.
`timescale 1ns/1ps
module csl_target_end (
  // System
  input wire logic clk,
  input wire logic rst,
  // Captured configuration data
  output logic cap_valid,
  output logic [csl_pkg::DATA_W-1:0] cap_bits,
  output logic cap_stage,
  input wire logic [3:0] lines_used,
  // Chain control
  input wire logic upstream_done,
  input wire logic cfg_complete,
  input wire logic error_req,
  input wire logic reconfig_req_n,
  // Flash host
  input wire logic host_req,
  input wire logic [csl_pkg::FLASH_AW-1:0] host_addr,
  output logic host_grant,
  // Link
  csl_link_if.target lnk
);
  logic sclk_meta;
  logic sclk_s;
  logic sclk_d;
  logic [csl_pkg::DATA_W-1:0] data_meta;
  logic [csl_pkg::DATA_W-1:0] data_s;
  logic status_meta;
  logic status_s;
  logic done_meta;
  logic done_s;
  logic fown_meta;
  logic fown_s;
  logic cap_valid_reg;
  logic [csl_pkg::DATA_W-1:0] cap_bits_reg;
  logic chain_en_reg;
  logic done_rel_reg;
  logic status_drv_reg;
  logic host_oe_reg;
  logic [csl_pkg::FLASH_AW-1:0] host_addr_reg;
  logic [csl_pkg::DATA_W-1:0] line_mask;
  logic rise;

  assign rise = sclk_s && !sclk_d;
  assign line_mask = csl_pkg::DATA_HIGH >> (4'h8 - lines_used);
  assign cap_valid = cap_valid_reg;
  assign cap_bits = cap_bits_reg;
  assign cap_stage = chain_en_reg;
  assign host_grant = !fown_s;
  assign lnk.tgt_status_out = '0;
  assign lnk.tgt_status_oe = status_drv_reg;
  assign lnk.tgt_done_out = '0;
  assign lnk.tgt_done_oe = !done_rel_reg;
  assign lnk.host_flash_oe = host_oe_reg;
  assign lnk.host_flash_addr = host_addr_reg;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      sclk_meta <= '0;
      sclk_s <= '0;
      sclk_d <= '0;
      data_meta <= '0;
      data_s <= '0;
      status_meta <= '0;
      status_s <= '0;
      done_meta <= '0;
      done_s <= '0;
      fown_meta <= '0;
      fown_s <= '0;
    end else begin
      sclk_meta <= lnk.config_shift_clock;
      sclk_s <= sclk_meta;
      sclk_d <= sclk_s;
      data_meta <= lnk.cfg_data;
      data_s <= data_meta;
      status_meta <= lnk.status_level;
      status_s <= status_meta;
      done_meta <= lnk.done_level;
      done_s <= done_meta;
      fown_meta <= lnk.dev_flash_oe;
      fown_s <= fown_meta;
    end
  end

  // Capture on the rising shift clock while configuring
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cap_valid_reg <= '0;
      cap_bits_reg <= '0;
    end else begin
      cap_valid_reg <= rise && status_s && !done_s;
      if (rise) begin
        cap_bits_reg <= data_s & line_mask;
      end
    end
  end

  // Downstream enable (cap_stage) sets after upstream finishes; capture is not gated by it
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      chain_en_reg <= '0;
    end else if (upstream_done) begin
      chain_en_reg <= '1;
    end else if (!status_s) begin
      chain_en_reg <= '0;
    end
  end

  // One shared done line for the chain
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      done_rel_reg <= '0;
    end else if (cfg_complete) begin
      done_rel_reg <= '1;
    end else if (!status_s) begin
      done_rel_reg <= '0;
    end
  end

  // Error or held reconfiguration pulls status low
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      status_drv_reg <= '0;
    end else begin
      status_drv_reg <= error_req || !reconfig_req_n;
    end
  end

  // Host drives flash only while the loader has released it; own pins only
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      host_oe_reg <= '0;
      host_addr_reg <= '0;
    end else begin
      host_oe_reg <= host_req && !fown_s;
      host_addr_reg <= (host_req && !fown_s) ? host_addr : '0;
    end
  end
endmodule

// >>> csl_link_asserts.sv
// Concurrent checks on the link between loader and target ends.
// Assumes link_clk clocks the loader's link side and rst resets it.
`timescale 1ns/1ps
module csl_link_asserts (
  // Clock and reset
  input wire logic link_clk,
  input wire logic rst,
  // Link signals
  input wire logic config_shift_clock,
  input wire logic [csl_pkg::DATA_W-1:0] cfg_data,
  input wire logic dev_status_oe,
  input wire logic status_level,
  input wire logic done_level
);
  logic [7:0] zf_reg;
  logic [7:0] oe_reg;
  default clocking @(posedge link_clk); endclocking
  default disable iff (rst);
  // Falls with zero data and done low
  always_ff @(posedge link_clk or posedge rst) begin
    if (rst) zf_reg <= 8'h00;
    else if (cfg_data != 8'h00 || done_level) zf_reg <= 8'h00;
    else if ($fell(config_shift_clock) && zf_reg != 8'hff) zf_reg <= zf_reg + 8'h01;
  end
  always_ff @(posedge link_clk or posedge rst) begin
    if (rst) oe_reg <= 8'h00;
    else if (!dev_status_oe) oe_reg <= 8'h00;
    else if (oe_reg != 8'hff) oe_reg <= oe_reg + 8'h01;
  end
  a_data_when_low: assert property ($changed(cfg_data) |-> !config_shift_clock)
    else $error("data changed while shift clock high");
  a_high_four: assert property (disable iff (rst || !status_level || done_level)
    $rose(config_shift_clock) |-> config_shift_clock [*4] ##1 !config_shift_clock)
    else $error("shift clock high phase not four cycles");
  a_low_min: assert property ($fell(config_shift_clock) |-> (!config_shift_clock) [*4])
    else $error("shift clock low phase too short");
  a_hold_fall: assert property (disable iff (rst || !status_level || done_level)
    $fell(config_shift_clock) |-> $stable(cfg_data))
    else $error("data moved at falling shift clock");
  a_start_done_low: assert property ($rose(config_shift_clock) |-> !$past(done_level, 6))
    else $error("shift clock ran with done high");
  a_status_stop: assert property ((!status_level) [*6] |-> !config_shift_clock)
    else $error("shift clock ran with status low");
  a_idle_levels: assert property ($rose(done_level) ##1 (done_level && status_level) [*4]
    |-> cfg_data == 8'hff && !config_shift_clock)
    else $error("idle levels wrong after done");
  // Last fall may land in the same cycle as the pulse
  a_timeout_count: assert property ($rose(dev_status_oe) |-> zf_reg >= 8'd63)
    else $error("status pulse before tail count");
  a_pulse_len: assert property ($fell(dev_status_oe) |-> oe_reg == 8'(csl_pkg::STATUS_PULSE_CYC))
    else $error("status pulse length wrong");
  c_err_pulse: cover property ($rose(dev_status_oe));
  c_done_seen: cover property ($rose(done_level));
  c_stop_run: cover property (!status_level && cfg_data != 8'h00);
endmodule

// >>> config_stream_output_and_flash_share_test.sv
// Self-checking bench joining loader and target ends across the link.
// Assumes the design files and the link checker are compiled first.
`timescale 1ns/1ps
module config_stream_output_and_flash_share_test;
  logic clk = 1'b0;
  logic link_clk = 1'b0;
  logic rst = 1'b1;
  logic feed_valid = 1'b0;
  logic feed_ready;
  logic [7:0] feed_byte = 8'h00;
  logic feed_last = 1'b0;
  csl_pkg::csl_width_e feed_width = csl_pkg::CSL_W1;
  logic opt_fetch = 1'b0;
  logic prog_write = 1'b0;
  logic [3:0] lines_used = 4'h8;
  logic pullup_off = 1'b0;
  logic [20:0] reader_addr = 21'h0a5a5;
  logic cfg_active;
  logic cfg_done;
  logic cap_valid;
  logic [7:0] cap_bits;
  logic cap_stage;
  logic upstream_done = 1'b0;
  logic cfg_complete = 1'b0;
  logic error_req = 1'b0;
  logic reconfig_req_n = 1'b1;
  logic host_req = 1'b0;
  logic [20:0] host_addr = 21'h1234c;
  logic host_grant;
  logic [7:0] capq[$];
  int err_count = 0;
  int total_checks = 0;
  int cyc = 0;
  always #12.5 clk = ~clk;
  always #6.0 link_clk = ~link_clk;
  csl_link_if lnk_if ();
  csl_config_end csl_config_end_inst (.clk(clk), .rst(rst), .link_clk(link_clk),
    .feed_valid(feed_valid), .feed_ready(feed_ready), .feed_byte(feed_byte),
    .feed_last(feed_last), .feed_width(feed_width), .opt_fetch(opt_fetch),
    .prog_write(prog_write), .reader_addr(reader_addr), .pullup_off(pullup_off),
    .cfg_active(cfg_active), .cfg_done(cfg_done), .lnk(lnk_if.device));
  csl_target_end csl_target_end_inst (.clk(clk), .rst(rst), .cap_valid(cap_valid),
    .cap_bits(cap_bits), .cap_stage(cap_stage), .lines_used(lines_used),
    .upstream_done(upstream_done), .cfg_complete(cfg_complete), .error_req(error_req),
    .reconfig_req_n(reconfig_req_n), .host_req(host_req), .host_addr(host_addr),
    .host_grant(host_grant), .lnk(lnk_if.target));
  csl_link_asserts csl_link_asserts_inst (.link_clk(link_clk), .rst(rst),
    .config_shift_clock(lnk_if.config_shift_clock), .cfg_data(lnk_if.cfg_data),
    .dev_status_oe(lnk_if.dev_status_oe), .status_level(lnk_if.status_level),
    .done_level(lnk_if.done_level));
  always @(negedge clk) if (cap_valid === 1'b1) capq.push_back(cap_bits);
  always @(posedge clk) begin
    cyc++;
    if (cyc == 40000) begin
      err_count++;
      conclude();
    end
  end
  task automatic conclude();
    $display("checks %0d mismatches %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    total_checks++;
    if (got !== exp) begin
      err_count++;
      $display("CHECK FAILED %s exp %h got %h", what, exp, got);
    end
  endtask
  function automatic logic [7:0] chunk(input logic [7:0] b, input int n, input int k);
    return 8'((b >> (k * n)) & ((9'h1 << n) - 9'h1));
  endfunction
  task automatic feed(input logic [7:0] b, input int w, input logic last);
    @(negedge clk);
    for (int i = 0; i < 400 && feed_ready !== 1'b1; i++) @(negedge clk);
    feed_valid = 1'b1;
    feed_byte = b;
    feed_width = csl_pkg::csl_width_e'(w);
    feed_last = last;
    @(negedge clk);
    feed_valid = 1'b0;
  endtask
  // Stream one or two bytes and compare each chunk captured for them
  task automatic stream(input int w, input int nb);
    int n;
    int per;
    logic [7:0] b [2];
    logic [7:0] mask;
    n = 1 << w;
    per = 8 / n;
    b = '{8'hc5, 8'h3a};
    for (int i = 0; i < 2000 && cfg_active !== 1'b1; i++) @(negedge clk);
    capq.delete();
    feed(b[0], w, nb == 1);
    repeat (3) @(negedge clk);
    chk("host_grant busy", 32'h0, 32'(host_grant));
    chk("flash pins", 32'(reader_addr), 32'(lnk_if.flash_addr_level));
    if (nb == 2) feed(b[1], 3 - w, 1'b1);
    for (int i = 0; i < 3000 && capq.size() < nb * per; i++) @(negedge clk);
    mask = 8'hff >> (4'h8 - lines_used);
    for (int j = 0; j < nb * per; j++) begin
      chk("lines", 32'(chunk(b[j / per], n, j % per) & mask), 32'(capq[j]));
    end
  endtask
  task automatic t_reset();
    chk("pull_en", 32'h1, 32'(lnk_if.dev_pull_en));
    chk("flash_oe", 32'h0, 32'(lnk_if.dev_flash_oe));
    chk("shift clock", 32'h0, 32'(lnk_if.config_shift_clock));
    $display("test reset done");
  endtask
  task automatic t_serial_timeout();
    stream(0, 2);
    for (int i = 0; i < 800 && lnk_if.dev_status_oe !== 1'b1; i++) @(negedge clk);
    chk("status pulse", 32'h1, 32'(lnk_if.dev_status_oe));
    $display("test serial timeout done");
  endtask
  task automatic t_error_mid();
    stream(1, 1);
    upstream_done = 1'b1;
    repeat (6) @(negedge clk);
    upstream_done = 1'b0;
    chk("chain enable", 32'h1, 32'(cap_stage));
    error_req = 1'b1;
    repeat (20) @(negedge clk);
    chk("active on error", 32'h0, 32'(cfg_active));
    chk("enable on error", 32'h0, 32'(cap_stage));
    chk("clock on error", 32'h0, 32'(lnk_if.config_shift_clock));
    error_req = 1'b0;
    for (int i = 0; i < 200 && cfg_active !== 1'b1; i++) @(negedge clk);
    chk("restart", 32'h1, 32'(cfg_active));
    $display("test error restart done");
  endtask
  task automatic t_full_done(input int w);
    lines_used = (w == 2) ? 4'h3 : 4'h8;
    stream(w, 2);
    cfg_complete = 1'b1;
    @(negedge clk);
    cfg_complete = 1'b0;
    for (int i = 0; i < 200 && cfg_done !== 1'b1; i++) @(negedge clk);
    chk("idle data", 32'hff, 32'(lnk_if.cfg_data));
    repeat (10) @(negedge clk);
    chk("flash released", 32'h0, 32'(lnk_if.dev_flash_oe));
    host_req = 1'b1;
    repeat (5) @(negedge clk);
    chk("host grant", 32'h1, 32'(host_grant));
    chk("host addr", 32'(host_addr), 32'(lnk_if.flash_addr_level));
    host_req = 1'b0;
    prog_write = (w == 3);
    opt_fetch = (w != 3);
    pullup_off = 1'b1;
    repeat (8) @(negedge clk);
    chk("option fetch oe", 32'h1, 32'(lnk_if.dev_flash_oe));
    chk("pull off", 32'h0, 32'(lnk_if.dev_pull_en));
    opt_fetch = 1'b0;
    prog_write = 1'b0;
    pullup_off = 1'b0;
    $display("test full cycle done");
  endtask
  task automatic t_reconfig();
    reconfig_req_n = 1'b0;
    repeat (20) @(negedge clk);
    chk("done on reconfig", 32'h0, 32'(cfg_done));
    chk("grant on reconfig", 32'h1, 32'(host_grant));
    reconfig_req_n = 1'b1;
    $display("test reconfig done");
  endtask
  initial begin
    repeat (2) @(negedge clk);
    t_reset();
    rst = 1'b0;
    t_serial_timeout();
    t_error_mid();
    t_full_done(2);
    t_reconfig();
    t_full_done(3);
    conclude();
  end
endmodule
